// ---- hdl/dbg_bkpt_pkg.sv ----
// Shared constants for the debug address breakpoint register slice.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package dbg_bkpt_pkg;

    // Debug control register numbers (5-bit register select)
    localparam logic [4:0] REG_CONFIG_STATUS = 5'h00;
    localparam logic [4:0] REG_ADDR_HIGH     = 5'h0C;
    localparam logic [4:0] REG_ADDR_LOW      = 5'h0D;
    // Attribute register number on the debug port
    localparam logic [4:0] REG_MEM_ATTR      = 5'h05;

    // Attribute register layout
    localparam int ATTR_RW_BIT  = 7;
    localparam int ATTR_SIZE_HI = 6;
    localparam int ATTR_SIZE_LO = 5;
    localparam int ATTR_TYPE_HI = 4;
    localparam int ATTR_TYPE_LO = 3;
    localparam int ATTR_MOD_HI  = 2;
    localparam int ATTR_MOD_LO  = 0;
    localparam logic [7:0] ATTR_RESET = 8'h05;

    // Transfer type encodings, shared with the attribute comparator
    localparam logic [1:0] XFER_NORMAL   = 2'h0;
    localparam logic [1:0] XFER_EXTERNAL = 2'h1;
    localparam logic [1:0] XFER_EMULATOR = 2'h2;
    localparam logic [1:0] XFER_CPU_ACK  = 2'h3;
    // Transfer modifier encodings for normal accesses
    localparam logic [2:0] MOD_LINE_PUSH  = 3'h0;
    localparam logic [2:0] MOD_USER_DATA  = 3'h1;
    localparam logic [2:0] MOD_USER_CODE  = 3'h2;
    localparam logic [2:0] MOD_SUPER_DATA = 3'h5;
    localparam logic [2:0] MOD_SUPER_CODE = 3'h6;

    // Configuration/status layout
    localparam int CSR_STATE_HI = 31;
    localparam int CSR_STATE_LO = 28;
    localparam int CSR_FOF_BIT  = 27;
    localparam int CSR_TRG_BIT  = 26;
    localparam int CSR_HALT_BIT = 25;
    localparam int CSR_BKPT_BIT = 24;
    localparam int CSR_HRL_HI   = 23;
    localparam int CSR_HRL_LO   = 20;
    localparam int CSR_RSVD_BIT = 7;
    localparam logic [3:0]  CSR_HRL_VALUE = 4'h1;
    localparam logic [31:0] CSR_WR_MASK   = 32'h0001_FF50;
    localparam logic [31:0] CSR_RESET     = 32'h0000_0000;

    // Breakpoint state field encodings
    localparam logic [3:0] BP_IDLE         = 4'h0;
    localparam logic [3:0] BP_WAIT_L1      = 4'h1;
    localparam logic [3:0] BP_TRIG_L1      = 4'h2;
    localparam logic [3:0] BP_WAIT_L2      = 4'h5;
    localparam logic [3:0] BP_TRIG_L2      = 4'h6;

    // Address comparison conditions from the trigger definition
    localparam logic [1:0] CMP_EQUAL   = 2'h0;
    localparam logic [1:0] CMP_INSIDE  = 2'h1;
    localparam logic [1:0] CMP_OUTSIDE = 2'h2;
    localparam logic [1:0] CMP_OFF     = 2'h3;

    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

endpackage

// ---- hdl/addr_range_cmp.sv ----
// Combinational address comparator against a low and a high bound.
// Assumes the bounds and condition are stable register outputs.
module addr_range_cmp (
    input  wire logic [1:0]  cond_i,
    input  wire logic [31:0] low_i,
    input  wire logic [31:0] high_i,
    input  wire logic [31:0] addr_i,
    output logic             match_o
);

    logic above_low;
    logic below_high;
    logic in_range;
    logic equal_low;

    // Bound tests, both ends inclusive
    assign above_low  = (addr_i >= low_i);
    assign below_high = (addr_i <= high_i);
    assign in_range   = above_low && below_high;
    assign equal_low  = (addr_i == low_i);

    // Condition select
    always_comb begin
        case (cond_i)
            dbg_bkpt_pkg::CMP_EQUAL:   match_o = equal_low;  // [RULE2]
            dbg_bkpt_pkg::CMP_INSIDE:  match_o = in_range;   // [RULE2]
            dbg_bkpt_pkg::CMP_OUTSIDE: match_o = !in_range;  // [RULE2]
            default:                   match_o = 1'b0;
        endcase
    end

endmodule

// ---- hdl/debug_address_breakpoint_regs.sv ----
// Debug register slice: address bounds, debug memory attributes and
// configuration/status, with the local-bus address comparator.
// Assumes core and debug-port requests are synchronous to ref_clk_i and
// that the breakpoint trigger logic supplies status and the condition.

// Contract
// RULE1 - Compare low and high bounds with every local-bus transfer address.
// RULE2 - Conditions: equal to low, inside inclusive range, or outside it.
// RULE3 - Low bound holds 32-bit lower limit; also the single exact address.
// RULE4 - High bound holds the 32-bit upper limit of the range.
// RULE5 - Supervisor writes high bound as register 0x0C; core cannot read.
// RULE6 - Low bound: supervisor write at 0x0D; debug port may only write.
// RULE7 - Debug port may read and write the high bound.
// RULE8 - Attribute reg gives direction, size, type, modifier for memory cmds.
// RULE9 - Attribute register resets to 0x5, supervisor data space.
// RULE10 - Type and modifier fields share the attribute comparator encodings.
// RULE11 - Config/status is write-only from core, read/write from debug port.
// RULE12 - Supervisor reaches config/status as debug register 0x00.
// RULE13 - Writers must put zero in config/status bit 7.
// RULE14 - Config/status merges debug configuration with breakpoint status.
// RULE15 - Type codes: 00 normal, 10 emulator, 11 CPU space, 01 external.
// RULE16 - State field: 0000 idle, 0001/0010 level one, 0101/0110 level two.
// RULE17 - One address-match indication per local-bus cycle, chosen by trigger.
module debug_address_breakpoint_regs (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Core debug-register write instruction
    input  wire logic        core_wr_i,
    input  wire logic        core_super_i,
    input  wire logic [4:0]  core_reg_i,
    input  wire logic [31:0] core_data_i,
    // Debug port register commands
    input  wire logic        dbg_wr_i,
    input  wire logic        dbg_rd_i,
    input  wire logic [4:0]  dbg_reg_i,
    input  wire logic [31:0] dbg_data_i,
    output logic [31:0]      dbg_rdata_o,
    output logic             dbg_rvalid_o,
    // Local bus under watch
    input  wire logic        lb_valid_i,
    input  wire logic [31:0] lb_addr_i,
    // Trigger definition condition and breakpoint status in
    input  wire logic [1:0]  trig_cond_i,
    input  wire logic [3:0]  bp_state_i,
    input  wire logic        fof_i,
    input  wire logic        trg_i,
    input  wire logic        halt_i,
    input  wire logic        bkpt_i,
    // Results
    output logic             addr_match_o,
    output logic             mem_read_o,
    output logic [1:0]       mem_size_o,
    output logic [1:0]       mem_type_o,
    output logic [2:0]       mem_mod_o,
    output logic [31:0]      config_o
);

    logic [31:0] addr_low_reg;
    logic [31:0] addr_low_next;
    logic [31:0] addr_high_reg;
    logic [31:0] addr_high_next;
    logic [7:0]  attr_reg;
    logic [7:0]  attr_next;
    logic [31:0] csr_ctrl_reg;
    logic [31:0] csr_ctrl_next;
    logic [7:0]  csr_stat_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        rvalid_reg;
    logic        match_reg;
    logic        cmp_hit;

    logic        core_ok;
    logic        wr_any;
    logic [4:0]  wr_sel;
    logic [31:0] wr_data;
    logic        wr_low;
    logic        wr_high;
    logic        wr_attr;
    logic        wr_csr;
    logic [31:0] csr_read_word;

    // Keep writable control bits, bit 7 always stored as zero
    function automatic logic [31:0] csr_merge(input logic [31:0] data);
        logic [31:0] masked;
        masked = data & dbg_bkpt_pkg::CSR_WR_MASK;
        masked[dbg_bkpt_pkg::CSR_RSVD_BIT] = 1'b0;
        return masked;
    endfunction

    // Register select test shared by both request paths
    function automatic logic reg_is(input logic [4:0] sel,
                                    input logic [4:0] num);
        return sel == num;
    endfunction

    // Write source: debug port wins over the core in the same cycle
    assign core_ok = core_wr_i && core_super_i;
    assign wr_any  = dbg_wr_i || core_ok;
    assign wr_sel  = dbg_wr_i ? dbg_reg_i : core_reg_i;
    assign wr_data = dbg_wr_i ? dbg_data_i : core_data_i;

    // Write decode; attribute register only via the debug port
    assign wr_low  = wr_any
                   && reg_is(wr_sel, dbg_bkpt_pkg::REG_ADDR_LOW);   // [RULE6]
    assign wr_high = wr_any
                   && reg_is(wr_sel, dbg_bkpt_pkg::REG_ADDR_HIGH);  // [RULE5]
    assign wr_csr  = wr_any && reg_is(wr_sel,
                     dbg_bkpt_pkg::REG_CONFIG_STATUS);         // [RULE12]
    assign wr_attr = dbg_wr_i
                   && reg_is(dbg_reg_i, dbg_bkpt_pkg::REG_MEM_ATTR);

    // Next values of the software-visible registers
    assign addr_low_next  = wr_low  ? wr_data : addr_low_reg;   // [RULE3]
    assign addr_high_next = wr_high ? wr_data : addr_high_reg;  // [RULE4]
    assign attr_next      = wr_attr ? wr_data[7:0] : attr_reg;  // [RULE8]
    // Reserved bit dropped whatever the writer sent
    assign csr_ctrl_next  = wr_csr ? csr_merge(wr_data)
                                   : csr_ctrl_reg;              // [RULE13]

    // Status word: breakpoint state over configuration bits
    assign csr_read_word = {csr_stat_reg,
                            dbg_bkpt_pkg::CSR_HRL_VALUE,
                            csr_ctrl_reg[19:0]};                // [RULE14]

    // Debug-port read mux; low bound and unknown numbers read zero
    always_comb begin
        case (dbg_reg_i)
            dbg_bkpt_pkg::REG_ADDR_HIGH:
                rdata_next = addr_high_reg;                     // [RULE7]
            dbg_bkpt_pkg::REG_CONFIG_STATUS:
                rdata_next = csr_read_word;                     // [RULE11]
            dbg_bkpt_pkg::REG_MEM_ATTR:
                rdata_next = {24'h00_0000, attr_reg};
            default:
                rdata_next = dbg_bkpt_pkg::ZERO_WORD;           // [RULE6]
        endcase
    end

    // Address comparator
    addr_range_cmp u_cmp (
        .cond_i  (trig_cond_i),
        .low_i   (addr_low_reg),
        .high_i  (addr_high_reg),
        .addr_i  (lb_addr_i),
        .match_o (cmp_hit)
    );

    // Bound registers
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            addr_low_reg  <= dbg_bkpt_pkg::ADDR_RESET;
            addr_high_reg <= dbg_bkpt_pkg::ADDR_RESET;
        end else if (ce_i) begin
            addr_low_reg  <= addr_low_next;
            addr_high_reg <= addr_high_next;
        end
    end

    // Attribute and configuration registers
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            attr_reg     <= dbg_bkpt_pkg::ATTR_RESET;           // [RULE9]
            csr_ctrl_reg <= dbg_bkpt_pkg::CSR_RESET;
        end else if (ce_i) begin
            attr_reg     <= attr_next;
            csr_ctrl_reg <= csr_ctrl_next;
        end
    end

    // Breakpoint status captured from the trigger logic
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            csr_stat_reg <= 8'h00;
        end else if (ce_i) begin
            csr_stat_reg <= {bp_state_i, fof_i, trg_i,
                             halt_i, bkpt_i};           // [RULE16]
        end
    end

    // Read answer one cycle after the command
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_reg  <= dbg_bkpt_pkg::ZERO_WORD;
            rvalid_reg <= 1'b0;
        end else if (ce_i) begin
            rvalid_reg <= dbg_rd_i;
            if (dbg_rd_i) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // One match flag per local-bus cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            match_reg <= 1'b0;
        end else if (ce_i) begin
            match_reg <= lb_valid_i && cmp_hit; // [RULE1] [RULE17]
        end
    end

    // Outputs straight from flip-flops
    assign dbg_rdata_o  = rdata_reg;
    assign dbg_rvalid_o = rvalid_reg;
    assign addr_match_o = match_reg;
    assign mem_read_o   = attr_reg[dbg_bkpt_pkg::ATTR_RW_BIT];
    assign mem_size_o   = attr_reg[dbg_bkpt_pkg::ATTR_SIZE_HI:
                                   dbg_bkpt_pkg::ATTR_SIZE_LO];
    // Same type/modifier codes as the attribute comparator
    assign mem_type_o   = attr_reg[dbg_bkpt_pkg::ATTR_TYPE_HI:   // [RULE15]
                                   dbg_bkpt_pkg::ATTR_TYPE_LO];  // [RULE10]
    assign mem_mod_o    = attr_reg[dbg_bkpt_pkg::ATTR_MOD_HI:
                                   dbg_bkpt_pkg::ATTR_MOD_LO];   // [RULE10]
    assign config_o     = csr_read_word;

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_match_inside_range: assert property ( // [RULE2]
        (ce_i && lb_valid_i && trig_cond_i == dbg_bkpt_pkg::CMP_INSIDE
         && lb_addr_i >= addr_low_reg && lb_addr_i <= addr_high_reg)
        |=> addr_match_o)
        else $error("inside-range address did not match");

    a_match_outside_rng: assert property ( // [RULE2]
        (ce_i && lb_valid_i && trig_cond_i == dbg_bkpt_pkg::CMP_OUTSIDE
         && lb_addr_i >= addr_low_reg && lb_addr_i <= addr_high_reg)
        |=> !addr_match_o)
        else $error("outside condition matched in range");

    a_match_equal_low: assert property ( // [RULE3]
        (ce_i && lb_valid_i && trig_cond_i == dbg_bkpt_pkg::CMP_EQUAL)
        |=> addr_match_o == (($past(lb_addr_i) == $past(addr_low_reg))))
        else $error("equal condition wrong");

    a_match_needs_bus: assert property ( // [RULE1]
        (ce_i && !lb_valid_i) |=> !addr_match_o)
        else $error("match without a bus transfer");

    a_high_core_write: assert property ( // [RULE5]
        (ce_i && core_wr_i && core_super_i && !dbg_wr_i
         && core_reg_i == dbg_bkpt_pkg::REG_ADDR_HIGH)
        |=> addr_high_reg == $past(core_data_i))
        else $error("high bound write lost");

    a_user_write_ignored: assert property ( // [RULE5]
        (ce_i && core_wr_i && !core_super_i && !dbg_wr_i)
        |=> $stable(addr_high_reg) && $stable(addr_low_reg)
            && $stable(csr_ctrl_reg))
        else $error("user mode write took effect");

    a_low_write_read0: assert property ( // [RULE6]
        (ce_i && dbg_wr_i && dbg_reg_i == dbg_bkpt_pkg::REG_ADDR_LOW)
        ##1 !(ce_i && wr_low)
        ##1 (ce_i && dbg_rd_i && dbg_reg_i == dbg_bkpt_pkg::REG_ADDR_LOW)
        |=> addr_low_reg == $past(dbg_data_i, 3) && dbg_rdata_o == 32'h0)
        else $error("low bound write or read wrong");

    a_high_read_back: assert property ( // [RULE7]
        (ce_i && dbg_rd_i && dbg_reg_i == dbg_bkpt_pkg::REG_ADDR_HIGH)
        |=> dbg_rvalid_o && dbg_rdata_o == $past(addr_high_reg))
        else $error("high bound read wrong");

    a_attr_reset: assert property ( // [RULE9]
        $fell(rst_i) |-> attr_reg == dbg_bkpt_pkg::ATTR_RESET)
        else $error("attribute reset value wrong");

    a_csr_bit7_zero: assert property ( // [RULE13]
        config_o[dbg_bkpt_pkg::CSR_RSVD_BIT] == 1'b0)
        else $error("reserved bit set");

    a_csr_core_write: assert property ( // [RULE12]
        (ce_i && core_ok && !dbg_wr_i
         && core_reg_i == dbg_bkpt_pkg::REG_CONFIG_STATUS)
        |=> config_o[19:0] == 20'(csr_merge($past(core_data_i))))
        else $error("config write lost");

    a_csr_status_read: assert property ( // [RULE14]
        (ce_i && dbg_rd_i && dbg_reg_i == dbg_bkpt_pkg::REG_CONFIG_STATUS)
        |=> dbg_rdata_o[31:28] == $past(csr_stat_reg[7:4]))
        else $error("status field not reported");

    a_type_from_attr: assert property ( // [RULE15]
        (ce_i && wr_attr) |=> mem_type_o == $past(dbg_data_i[4:3]))
        else $error("transfer type field wrong");

    a_attr_core_refused: assert property ( // [RULE8]
        (ce_i && core_wr_i && !dbg_wr_i) |=> $stable(attr_reg))
        else $error("core write reached the attribute register");

    a_match_off_cond: assert property ( // [RULE17]
        (ce_i && trig_cond_i == dbg_bkpt_pkg::CMP_OFF) |=> !addr_match_o)
        else $error("match with the comparison turned off");

    a_rvalid_one_cycle: assert property ( // [RULE11]
        (ce_i && !dbg_rd_i) |=> !dbg_rvalid_o)
        else $error("read valid without a read command");

    c_range_hit:    cover property (ce_i && lb_valid_i && cmp_hit
                                    && trig_cond_i == dbg_bkpt_pkg::CMP_INSIDE);
    c_outside_hit:  cover property (addr_match_o
                                    && trig_cond_i == dbg_bkpt_pkg::CMP_OUTSIDE);
    c_csr_read:     cover property (dbg_rvalid_o && config_o[31:28]
                                    == dbg_bkpt_pkg::BP_TRIG_L2);
    c_low_read_0:   cover property (dbg_rvalid_o
                                    && dbg_rdata_o == dbg_bkpt_pkg::ZERO_WORD);
    c_both_writers: cover property (ce_i && dbg_wr_i && core_ok);

endmodule

// ---- testbench/dbg_host_model.sv ----
// Debug host model driving the debug-port register commands.
// Assumes the block answers a read with a one-cycle valid pulse.
module dbg_host_model (
    input  wire logic        ref_clk_i,
    input  wire logic [31:0] dbg_rdata_i,
    input  wire logic        dbg_rvalid_i,
    output logic             dbg_wr_o,
    output logic             dbg_rd_o,
    output logic [4:0]       dbg_reg_o,
    output logic [31:0]      dbg_data_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle command lines at time zero
    initial begin
        dbg_wr_o = 1'b0;
        dbg_rd_o = 1'b0;
        dbg_reg_o = 5'h1F;
        dbg_data_o = 32'h0000_0000;
    end

    // Register write command, one cycle, lines scrambled after release
    task automatic wr(input logic [4:0] num, input logic [31:0] data);
        @(negedge ref_clk_i);
        dbg_wr_o = 1'b1;
        dbg_reg_o = num;
        dbg_data_o = data;
        if (num == dbg_bkpt_pkg::REG_CONFIG_STATUS) begin
            dbg_data_o[7] = 1'b0; // Reserved bit sent as zero
        end
        @(negedge ref_clk_i);
        dbg_wr_o = 1'b0;
        dbg_reg_o = ~num;
        dbg_data_o = ~dbg_data_o;
    endtask

    // Register read command; answer taken one cycle after the request
    task automatic rd(input logic [4:0] num, output logic [31:0] data,
                      output logic ok);
        @(negedge ref_clk_i);
        dbg_rd_o = 1'b1;
        dbg_reg_o = num;
        @(negedge ref_clk_i);
        dbg_rd_o = 1'b0;
        dbg_reg_o = ~num;
        data = dbg_rdata_i;
        ok = dbg_rvalid_i;
    endtask
endmodule

// ---- testbench/tb_debug_address_breakpoint_regs.sv ----
// Self-checking bench for the debug address breakpoint register slice.
// Assumes the debug host model and the design package are compiled first.
module tb_debug_address_breakpoint_regs;
    timeunit 1ns;
    timeprecision 1ns;

    logic        ref_clk_i, rst_i, ce_i, core_wr_i, core_super_i;
    logic [4:0]  core_reg_i, dbg_reg_i;
    logic [31:0] core_data_i, dbg_data_i, dbg_rdata_o, lb_addr_i, config_o;
    logic        dbg_wr_i, dbg_rd_i, dbg_rvalid_o, lb_valid_i, addr_match_o;
    logic [1:0]  trig_cond_i, mem_size_o, mem_type_o;
    logic [3:0]  bp_state_i;
    logic        fof_i, trg_i, halt_i, bkpt_i, mem_read_o;
    logic [2:0]  mem_mod_o;
    logic [31:0] rdat;
    logic        rok;
    int          n_mismatch = 0;
    int          compares = 0;

    debug_address_breakpoint_regs dut_u (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .core_wr_i(core_wr_i), .core_super_i(core_super_i),
        .core_reg_i(core_reg_i), .core_data_i(core_data_i),
        .dbg_wr_i(dbg_wr_i), .dbg_rd_i(dbg_rd_i), .dbg_reg_i(dbg_reg_i),
        .dbg_data_i(dbg_data_i), .dbg_rdata_o(dbg_rdata_o),
        .dbg_rvalid_o(dbg_rvalid_o), .lb_valid_i(lb_valid_i),
        .lb_addr_i(lb_addr_i), .trig_cond_i(trig_cond_i),
        .bp_state_i(bp_state_i), .fof_i(fof_i), .trg_i(trg_i), .halt_i(halt_i),
        .bkpt_i(bkpt_i), .addr_match_o(addr_match_o),
        .mem_read_o(mem_read_o), .mem_size_o(mem_size_o),
        .mem_type_o(mem_type_o), .mem_mod_o(mem_mod_o), .config_o(config_o));

    dbg_host_model host_u (
        .ref_clk_i(ref_clk_i), .dbg_rdata_i(dbg_rdata_o),
        .dbg_rvalid_i(dbg_rvalid_o), .dbg_wr_o(dbg_wr_i),
        .dbg_rd_o(dbg_rd_i), .dbg_reg_o(dbg_reg_i), .dbg_data_o(dbg_data_i));

    // Clock at 100 MHz
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Core debug-register write, one-cycle strobe
    task automatic core_wr(input logic [4:0] num, input logic [31:0] d,
                           input logic sup);
        @(negedge ref_clk_i);
        core_wr_i = 1'b1;
        core_super_i = sup;
        core_reg_i = num;
        core_data_i = d;
        @(negedge ref_clk_i);
        core_wr_i = 1'b0;
        core_data_i = ~d;
    endtask

    // Debug read, checking the valid pulse and the data
    task automatic host_chk(input logic [4:0] num, input logic [31:0] exp);
        host_u.rd(num, rdat, rok);
        chk({31'h0, rok}, 32'h1);
        chk(rdat, exp);
    endtask

    // One local-bus transfer, match seen one cycle later
    task automatic lb(input logic [1:0] c, input logic [31:0] a,
                      input logic v, input logic e);
        @(negedge ref_clk_i);
        lb_valid_i = v;
        lb_addr_i = a;
        trig_cond_i = c;
        @(negedge ref_clk_i);
        lb_valid_i = 1'b0;
        lb_addr_i = ~a;
        chk({31'h0, addr_match_o}, {31'h0, e});
    endtask

    task automatic t_reset();
        chk(config_o, 32'h0010_0000);
        chk({24'h0, mem_read_o, mem_size_o, mem_type_o, mem_mod_o},
            {24'h0, dbg_bkpt_pkg::ATTR_RESET});
        host_chk(dbg_bkpt_pkg::REG_MEM_ATTR, 32'h0000_0005);
    endtask

    task automatic t_bounds();
        core_wr(dbg_bkpt_pkg::REG_ADDR_HIGH, 32'hA5A5_0F0F, 1'b1);
        host_chk(dbg_bkpt_pkg::REG_ADDR_HIGH, 32'hA5A5_0F0F);
        core_wr(dbg_bkpt_pkg::REG_ADDR_HIGH, 32'h0000_0001, 1'b0);
        host_chk(dbg_bkpt_pkg::REG_ADDR_HIGH, 32'hA5A5_0F0F);
        host_u.wr(dbg_bkpt_pkg::REG_ADDR_HIGH, 32'hFFFF_FFFE);
        host_chk(dbg_bkpt_pkg::REG_ADDR_HIGH, 32'hFFFF_FFFE);
        core_wr(dbg_bkpt_pkg::REG_ADDR_HIGH, 32'h0000_0200, 1'b1);
        host_u.wr(dbg_bkpt_pkg::REG_ADDR_LOW, 32'h0000_0100);
        host_chk(dbg_bkpt_pkg::REG_ADDR_LOW, 32'h0000_0000);
    endtask

    task automatic t_compare();
        lb(2'h0, 32'h0000_0100, 1'b1, 1'b1);
        lb(2'h0, 32'h0000_0101, 1'b1, 1'b0);
        lb(2'h1, 32'h0000_0100, 1'b1, 1'b1);
        lb(2'h1, 32'h0000_0200, 1'b1, 1'b1);
        lb(2'h1, 32'h0000_0201, 1'b1, 1'b0);
        lb(2'h1, 32'h0000_00FF, 1'b1, 1'b0);
        lb(2'h2, 32'h0000_00FF, 1'b1, 1'b1);
        lb(2'h2, 32'h0000_0150, 1'b1, 1'b0);
        lb(2'h3, 32'h0000_0150, 1'b1, 1'b0);
        lb(2'h1, 32'h0000_0150, 1'b0, 1'b0);
        core_wr(dbg_bkpt_pkg::REG_ADDR_LOW, 32'h0000_0180, 1'b1);
        lb(2'h0, 32'h0000_0180, 1'b1, 1'b1);
    endtask

    // Clock enable low: a debug write is not taken
    task automatic t_freeze();
        @(negedge ref_clk_i);
        ce_i = 1'b0;
        host_u.wr(dbg_bkpt_pkg::REG_ADDR_HIGH, 32'h1234_5678);
        ce_i = 1'b1;
        host_chk(dbg_bkpt_pkg::REG_ADDR_HIGH, 32'h0000_0200);
    endtask

    task automatic t_attr();
        logic [7:0] v;
        for (int t = 0; t < 4; t++) begin
            v = {1'b1, 2'(t), 2'(t), 3'(t + 1)};
            host_u.wr(dbg_bkpt_pkg::REG_MEM_ATTR, {24'h0, v});
            chk({24'h0, mem_read_o, mem_size_o, mem_type_o, mem_mod_o},
                {24'h0, v});
        end
        core_wr(dbg_bkpt_pkg::REG_MEM_ATTR, 32'h0000_0000, 1'b1);
        host_chk(dbg_bkpt_pkg::REG_MEM_ATTR, {24'h0, v});
    endtask

    task automatic t_csr();
        logic [3:0] codes [5];
        logic [7:0] st;
        codes = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6};
        for (int i = 0; i < 5; i++) begin
            st = {codes[i], 4'(i + 9)};
            @(negedge ref_clk_i);
            {bp_state_i, fof_i, trg_i, halt_i, bkpt_i} = st;
            repeat (3) @(negedge ref_clk_i);
            chk({24'h0, config_o[31:24]}, {24'h0, st});
        end
        // Core keeps the reserved bit clear
        core_wr(dbg_bkpt_pkg::REG_CONFIG_STATUS, 32'hFFFF_FF7F,
                1'b1);
        host_chk(dbg_bkpt_pkg::REG_CONFIG_STATUS,
                 {st, 24'h11_FF50});
        host_u.wr(dbg_bkpt_pkg::REG_CONFIG_STATUS, 32'h0000_0090);
        host_chk(dbg_bkpt_pkg::REG_CONFIG_STATUS,
                 {st, 24'h10_0010});
    endtask

    // Watchdog
    initial begin
        #20000;
        n_mismatch++;
        close_out();
    end

    // Main sequence
    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        core_wr_i = 1'b0;
        core_super_i = 1'b0;
        core_reg_i = 5'h1F;
        core_data_i = 32'h0000_0000;
        lb_valid_i = 1'b0;
        lb_addr_i = 32'h0000_0000;
        trig_cond_i = 2'h3;
        {bp_state_i, fof_i, trg_i, halt_i, bkpt_i} = 8'h00;
        repeat (4) @(negedge ref_clk_i);
        rst_i = 1'b0;
        t_reset();
        t_bounds();
        t_compare();
        t_freeze();
        t_attr();
        t_csr();
        close_out();
    end
endmodule
